/* gpx_edge_irq.sv */
`timescale 1ns/1ps
`default_nettype none
module gpx_edge_irq
    import gpx_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    input wire logic [15:0] pinIn,
    input wire logic [15:0] pinDirection,
    output logic [7:0] pulldownEnableA,
    output logic irq_out_n
);
    gpx_state_t s_q;
    gpx_state_t s_d;

    // ----------------------------------------
    // Sense fields: line n sits at bits 2n+1:2n of the 32-bit packing
    // ----------------------------------------
    function automatic logic [7:0] senseByte(input logic [31:0] sense, input int hi, input int lo);
        senseByte = {sense[hi*2 +: 2], sense[(hi-1)*2 +: 2], sense[(lo+1)*2 +: 2], sense[lo*2 +: 2]};
    endfunction : senseByte

    logic [31:0] senseNew;
    logic [15:0] riseHit;
    logic [15:0] fallHit;
    logic [15:0] edgeHit;
    logic [15:0] senseChanged;
    logic [15:0] clrA;

    // ----------------------------------------
    // Next state: pin pipeline, register writes, event and pending flags
    // ----------------------------------------
    always_comb
    begin
        s_d = s_q;
        senseNew = s_q.sense;
        clrA = 16'h0000;
        s_d.syncA = pinIn;
        s_d.syncB = s_q.syncA;
        s_d.prev = s_q.syncB;
        s_d.primed = 1'b1;
        riseHit = s_q.primed ? (s_q.syncB & ~s_q.prev) : 16'h0000;
        fallHit = s_q.primed ? (~s_q.syncB & s_q.prev) : 16'h0000;
        if (regWrite)
        begin
            case (regAddr)
                ADDR_PULLDOWN_A: s_d.pulldownA = regWdata;
                ADDR_MASK_B: s_d.mask[15:8] = regWdata;
                ADDR_MASK_A: s_d.mask[7:0] = regWdata;
                ADDR_SENSE_HI_B: senseNew[31:24] = regWdata;
                ADDR_SENSE_HI_A: senseNew[15:8] = regWdata;
                ADDR_SENSE_LO_B: senseNew[23:16] = regWdata;
                ADDR_SENSE_LO_A: senseNew[7:0] = regWdata;
                ADDR_PENDING_B, ADDR_SEEN_B: clrA[15:8] = regWdata;
                ADDR_PENDING_A, ADDR_SEEN_A: clrA[7:0] = regWdata;
                default: ;
            endcase
        end
        s_d.sense = senseNew;
        for (int i = 0; i < 16; i++)
        begin
            senseChanged[i] = senseNew[2*i +: 2] != s_q.sense[2*i +: 2];
            edgeHit[i] = (riseHit[i] & |(s_q.sense[2*i +: 2] & SENSE_RISE_BIT))
                       | (fallHit[i] & |(s_q.sense[2*i +: 2] & SENSE_FALL_BIT));
        end
        // Set wins over a simultaneous clear
        s_d.seen = (s_q.seen & ~clrA & ~senseChanged) | edgeHit;
        s_d.pending = (s_q.pending & ~clrA)
                    | (edgeHit & ~s_q.mask & pinDirection);
        s_d.irqOutN = ~|s_d.pending;
        s_d.pulldownOut = s_d.pulldownA;
        s_d.rdata = s_q.rdata;
        if (regRead)
        begin
            case (regAddr)
                ADDR_PULLDOWN_A: s_d.rdata = s_q.pulldownA;
                ADDR_MASK_B: s_d.rdata = s_q.mask[15:8];
                ADDR_MASK_A: s_d.rdata = s_q.mask[7:0];
                ADDR_SENSE_HI_B: s_d.rdata = senseByte(s_q.sense, 15, 12);
                ADDR_SENSE_HI_A: s_d.rdata = senseByte(s_q.sense, 7, 4);
                ADDR_SENSE_LO_B: s_d.rdata = senseByte(s_q.sense, 11, 8);
                ADDR_SENSE_LO_A: s_d.rdata = senseByte(s_q.sense, 3, 0);
                ADDR_PENDING_B: s_d.rdata = s_q.pending[15:8];
                ADDR_PENDING_A: s_d.rdata = s_q.pending[7:0];
                ADDR_SEEN_B: s_d.rdata = s_q.seen[15:8];
                ADDR_SEEN_A: s_d.rdata = s_q.seen[7:0];
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            s_q <= '0;
            s_q.pulldownA <= RST_PULLDOWN;
            s_q.mask <= {RST_MASK, RST_MASK};
            s_q.sense <= {4{RST_SENSE}};
            s_q.pulldownOut <= RST_PULLDOWN;
            s_q.irqOutN <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign regRdata = s_q.rdata;
    assign pulldownEnableA = s_q.pulldownOut;
    assign irq_out_n = s_q.irqOutN;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence seqPendingAny;
        |s_q.pending;
    endsequence

    sequence seqWriteMaskA;
        regWrite && regAddr == ADDR_MASK_A;
    endsequence

    sequence seqWriteMaskB;
        regWrite && regAddr == ADDR_MASK_B;
    endsequence

    sequence seqClearLine0;
        regWrite && regAddr == ADDR_SEEN_A && regWdata[0] && !edgeHit[0];
    endsequence

    AST_RESET_MASKED: assert property (@(posedge clk) $fell(sys_rst) |-> s_q.mask == 16'hffff)
        else $error("mask not all ones after reset");
    AST_PULLDOWN_RESET: assert property (@(posedge clk)
        $fell(sys_rst) |-> pulldownEnableA == RST_PULLDOWN)
        else $error("pull-down not cleared after reset");
    AST_IRQ_RESET: assert property (@(posedge clk)
        $fell(sys_rst) |-> irq_out_n)
        else $error("irq low after reset");
    AST_IRQ_LOW: assert property (@(posedge clk) disable iff (sys_rst)
        seqPendingAny |=> !irq_out_n || $past(clrA) != 16'h0000)
        else $error("irq not low while pending");
    AST_IRQ_HIGH: assert property (@(posedge clk) disable iff (sys_rst)
        !irq_out_n |-> |s_q.pending)
        else $error("irq low with nothing pending");
    AST_MASKED_QUIET: assert property (@(posedge clk) disable iff (sys_rst)
        (edgeHit & s_q.mask & ~s_q.pending) != 16'h0000 && clrA == 16'h0000
        |=> (s_q.pending & $past(edgeHit & s_q.mask & ~s_q.pending)) == 16'h0000)
        else $error("masked line raised pending");
    AST_UNMASKED_SETS: assert property (@(posedge clk) disable iff (sys_rst)
        (edgeHit & ~s_q.mask & pinDirection) != 16'h0000
        |=> (s_q.pending & $past(edgeHit & ~s_q.mask & pinDirection))
            == $past(edgeHit & ~s_q.mask & pinDirection))
        else $error("unmasked event lost");
    AST_SEEN_SETS: assert property (@(posedge clk) disable iff (sys_rst)
        edgeHit != 16'h0000 |=> (s_q.seen & $past(edgeHit)) == $past(edgeHit))
        else $error("event status not set");
    AST_CLEAR_BOTH: assert property (@(posedge clk) disable iff (sys_rst)
        seqClearLine0 |=> !s_q.pending[0] && !s_q.seen[0])
        else $error("write of one did not clear line 0");
    AST_RISE_ONLY: assert property (@(posedge clk) disable iff (sys_rst)
        s_q.sense[1:0] == 2'h1 && fallHit[0] |-> !edgeHit[0])
        else $error("falling edge seen in rising mode");
    AST_FALL_ONLY: assert property (@(posedge clk) disable iff (sys_rst)
        s_q.sense[1:0] == 2'h2 && riseHit[0] |-> !edgeHit[0])
        else $error("rising edge seen in falling mode");
    AST_NONE_QUIET: assert property (@(posedge clk) disable iff (sys_rst)
        s_q.sense[1:0] == 2'h0 |-> !edgeHit[0])
        else $error("edge seen with detection off");
    AST_RISE_DETECT: assert property (@(posedge clk) disable iff (sys_rst)
        s_q.primed && s_q.syncB[0] && !s_q.prev[0] |-> riseHit[0])
        else $error("rising change not flagged");
    AST_SENSE_CLEARS: assert property (@(posedge clk) disable iff (sys_rst)
        senseChanged[0] && !edgeHit[0] |=> !s_q.seen[0])
        else $error("sense change kept event status");
    AST_MASK_A_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
        seqWriteMaskA |=> s_q.mask[7:0] == $past(regWdata))
        else $error("bank A mask write lost");
    AST_MASK_B_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
        seqWriteMaskB |=> s_q.mask[15:8] == $past(regWdata))
        else $error("bank B mask write lost");
    AST_SENSE_HI_B: assert property (@(posedge clk) disable iff (sys_rst)
        regWrite && regAddr == ADDR_SENSE_HI_B |=> s_q.sense[31:24] == $past(regWdata))
        else $error("upper bank B sense misplaced");
    AST_SENSE_HI_A: assert property (@(posedge clk) disable iff (sys_rst)
        regWrite && regAddr == ADDR_SENSE_HI_A |=> s_q.sense[15:8] == $past(regWdata))
        else $error("upper bank A sense misplaced");
    AST_SENSE_LINE4: assert property (@(posedge clk) disable iff (sys_rst)
        regWrite && regAddr == ADDR_SENSE_HI_A |=> s_q.sense[9:8] == $past(regWdata[1:0]))
        else $error("line 4 sense misplaced");
    AST_SENSE_LO_B: assert property (@(posedge clk) disable iff (sys_rst)
        regWrite && regAddr == ADDR_SENSE_LO_B |=> s_q.sense[23:16] == $past(regWdata))
        else $error("lower bank B sense misplaced");
    AST_SENSE_LO_A: assert property (@(posedge clk) disable iff (sys_rst)
        regWrite && regAddr == ADDR_SENSE_LO_A |=> s_q.sense[7:0] == $past(regWdata))
        else $error("lower bank A sense misplaced");
    AST_OUTPUT_LINE: assert property (@(posedge clk) disable iff (sys_rst)
        pinDirection[0] == 1'b0 && !s_q.pending[0] |=> !s_q.pending[0] || $past(regWrite))
        else $error("output line raised pending");
    AST_PULLDOWN: assert property (@(posedge clk) disable iff (sys_rst)
        regWrite && regAddr == ADDR_PULLDOWN_A |=> pulldownEnableA == $past(regWdata))
        else $error("pull-down output mismatch");
endmodule : gpx_edge_irq
`default_nettype wire

/* gpx_edge_irq_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// --------
// Register, edge and interrupt scenarios
// --------
module gpx_edge_irq_tb import gpx_pkg::*; ();
    logic clk = 1'b0;
    logic sysRst = 1'b1;
    logic [15:0] pinIn = 16'h0000;
    logic [15:0] pinDir = 16'hffff;
    logic wrS, rdS, irqN;
    logic [7:0] adr, wd, rdat, pdA;
    int errors = 0;
    int checks = 0;
    always #10 clk = ~clk;
    gpx_host_model i_host (.clk(clk), .regRdata(rdat), .regWrite(wrS), .regRead(rdS),
        .regAddr(adr), .regWdata(wd));
    gpx_edge_irq i_dut (.clk(clk), .sys_rst(sysRst), .regWrite(wrS), .regRead(rdS),
        .regAddr(adr), .regWdata(wd), .regRdata(rdat), .pinIn(pinIn),
        .pinDirection(pinDir), .pulldownEnableA(pdA), .irq_out_n(irqN));
    task cmp(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    task chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_host.rd(a, d);
        cmp($sformatf("reg %h", a), e, d);
    endtask : chk
    task pins(input logic [15:0] v);
        @(posedge clk);
        #1;
        pinIn = v;
        repeat (6) @(posedge clk);
    endtask : pins
    task t_reset();
        chk(ADDR_MASK_A, RST_MASK);
        chk(ADDR_MASK_B, RST_MASK);
        cmp("irq", 8'h01, {7'h00, irqN});
    endtask : t_reset
    task t_pulldown();
        i_host.wr(ADDR_PULLDOWN_A, 8'ha5);
        i_host.wr(8'h20, 8'h5a);
        chk(8'h20, 8'h00);
        cmp("pulldown", 8'ha5, pdA);
    endtask : t_pulldown
    task t_sense();
        i_host.wr(ADDR_SENSE_HI_A, 8'he4);
        i_host.wr(ADDR_SENSE_LO_A, 8'he4);
        i_host.wr(ADDR_SENSE_HI_B, 8'he4);
        i_host.wr(ADDR_SENSE_LO_B, 8'he4);
        pins(16'hffff);
        chk(ADDR_SEEN_A, 8'haa);
        chk(ADDR_SEEN_B, 8'haa);
        chk(ADDR_PENDING_A, 8'h00);
        cmp("irq", 8'h01, {7'h00, irqN});
        i_host.wr(ADDR_SEEN_A, 8'hff);
        i_host.wr(ADDR_SEEN_B, 8'hff);
        pins(16'h0000);
        chk(ADDR_SEEN_A, 8'hcc);
        chk(ADDR_SEEN_B, 8'hcc);
    endtask : t_sense
    task t_irq();
        i_host.wr(ADDR_SEEN_A, 8'hff);
        i_host.wr(ADDR_SEEN_B, 8'hff);
        pinDir = 16'h00ff;
        i_host.wr(ADDR_MASK_A, 8'h00);
        i_host.wr(ADDR_MASK_B, 8'h00);
        pins(16'hffff);
        chk(ADDR_PENDING_A, 8'haa);
        chk(ADDR_PENDING_B, 8'h00);
        cmp("irq", 8'h00, {7'h00, irqN});
        i_host.wr(ADDR_PENDING_A, 8'hff);
        chk(ADDR_SEEN_A, 8'h00);
        chk(ADDR_SEEN_B, 8'haa);
        cmp("irq", 8'h01, {7'h00, irqN});
    endtask : t_irq
    task t_change();
        pins(16'h0000);
        i_host.wr(ADDR_SENSE_LO_A, 8'h24);
        chk(ADDR_SEEN_A, 8'hc4);
        cmp("irq", 8'h00, {7'h00, irqN});
        i_host.wr(ADDR_PENDING_A, 8'hff);
        cmp("irq", 8'h01, {7'h00, irqN});
    endtask : t_change
    task test_done();
        if (errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    initial
    begin
        #400000;
        errors++;
        test_done();
    end
    initial
    begin
        repeat (20) @(posedge clk);
        #1;
        sysRst = 1'b0;
        t_reset();
        t_pulldown();
        t_sense();
        t_irq();
        t_change();
        test_done();
    end
endmodule : gpx_edge_irq_tb
`default_nettype wire

/* gpx_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// --------
// Host side register access
// --------
module gpx_host_model (
    input wire logic clk,
    input wire logic [7:0] regRdata,
    output logic regWrite,
    output logic regRead,
    output logic [7:0] regAddr,
    output logic [7:0] regWdata
);
    initial
    begin
        {regWrite, regRead, regAddr, regWdata} = 18'h0;
    end
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        {regWrite, regAddr, regWdata} = {1'b1, a, d};
        @(posedge clk);
        #1;
        {regWrite, regAddr, regWdata} = {1'b0, ~a, ~d};
    endtask : wr
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        {regRead, regAddr} = {1'b1, a};
        @(posedge clk);
        #1;
        {regRead, regAddr} = {1'b0, ~a};
        d = regRdata;
    endtask : rd
endmodule : gpx_host_model
`default_nettype wire

/* gpx_pkg.sv */
// What this block does
// - Each low-bank pull-down enable bit drives that pin's pull-down directly.
// - Mask bits apply to input lines only; both masks reset to all masked.
// - Mask bit 0 lets a detected event raise the interrupt output.
// - Mask bit 1 keeps events on that line off the interrupt output.
// - Sense code 00 none, 01 rising, 10 falling, 11 both edges.
// - Upper bank B sense: line 15 bits 7:6, 14 bits 5:4, then 13, 12.
// - Upper bank A sense: line 7 bits 7:6, then lines 6 and 5 descending.
// - Upper bank A sense: line 4 sits in bits 1:0.
// - Lower bank B sense: lines 11,10,9,8 in bits 7:6,5:4,3:2,1:0.
// - Lower bank A sense: line 3 in bits 7:6, lower lines descending.
// - Selected edge sets event status; writing 1 clears it and the pending bit.
// - Interrupt output returns high once all pending bits are clear.
// - Changing a line's sense field clears that line's event status bit.
// - Direction 0 is output, 1 input; only inputs raise unmasked interrupts.
package gpx_pkg;
    localparam logic [7:0] ADDR_PULLDOWN_A = 8'h07;
    localparam logic [7:0] ADDR_MASK_B = 8'h08;
    localparam logic [7:0] ADDR_MASK_A = 8'h09;
    localparam logic [7:0] ADDR_SENSE_HI_B = 8'h0a;
    localparam logic [7:0] ADDR_SENSE_HI_A = 8'h0b;
    localparam logic [7:0] ADDR_SENSE_LO_B = 8'h0c;
    localparam logic [7:0] ADDR_SENSE_LO_A = 8'h0d;
    localparam logic [7:0] ADDR_PENDING_B = 8'h0e;
    localparam logic [7:0] ADDR_PENDING_A = 8'h0f;
    localparam logic [7:0] ADDR_SEEN_B = 8'h10;
    localparam logic [7:0] ADDR_SEEN_A = 8'h11;
    localparam logic [7:0] RST_PULLDOWN = 8'h00;
    localparam logic [7:0] RST_MASK = 8'hff;
    localparam logic [7:0] RST_SENSE = 8'h00;
    localparam logic [1:0] SENSE_RISE_BIT = 2'h1;
    localparam logic [1:0] SENSE_FALL_BIT = 2'h2;

    typedef struct packed {
        logic [7:0] pulldownA;
        logic [15:0] mask;
        logic [31:0] sense;
        logic [15:0] pending;
        logic [15:0] seen;
        logic [15:0] syncA;
        logic [15:0] syncB;
        logic [15:0] prev;
        logic primed;
        logic [7:0] rdata;
        logic [7:0] pulldownOut;
        logic irqOutN;
    } gpx_state_t;
endpackage : gpx_pkg
